// ==== rcsc_top.sv ====
// Clock generation, gear, glitch-free system clock select, standby modes, Wishbone registers
//
// Contract
// RL1: Reset held at least 12 clock periods
// RL2: Strap sampled at release picks PLL/bypass
// RL3: Gear defaults to divide-by-eight
// RL4: Reset fetches from fixed NMI-shared vector
// RL5: Reset restores every peripheral register
// RL6: Reset sets all port pins GPIO
// RL7: Reset leaves on-chip RAM untouched
// RL8: Single-clock and dual-clock configurations supported
// RL9: SLOW/SLEEP only with stable low-speed clock; STOP exit loads rsysck into the source select without checking ls_stable_q
// RL10: SLEEP exit resumes previous mode
// RL11: STOP exit enters programmed control0 mode
// RL12: PLL multiplies by four, else bypassed
// RL13: Gear divides by 1, 2, 4, 8
// RL14: Divide-factor bit resets to zero
// RL15: SLOW mode clocks CPU from low-speed
// RL16: SLEEP halts all but real-time counter
// RL17: Prescaler output below half system clock
// RL18: Peripherals off while low-speed clock runs
// RL19: No prescaler source switch while running
// RL20: High/low clock switch is glitch-free
`timescale 1ns/1ns
`default_nettype none
module rcsc_top
  import rcsc_pkg::*;
#(
  parameter int WARMUP_CYCLES = 4096,
  parameter int LS_STABLE_EDGES = 8
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Pins
  input wire logic i_pll_bypass_strap,
  input wire logic i_low_speed_clock,
  input wire logic i_wake,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [ADDR_W-1:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic o_wb_ack,
  output logic [31:0] o_wb_dat,
  // Clock enables, reset outputs, prescaler select and mode
  output logic o_sys_clk_en,
  output logic o_cpu_clk_en,
  output logic o_periph_clk_en,
  output logic o_rtc_clk_en,
  output logic o_periph_rst,
  output logic o_port_gpio_init,
  output logic o_vector_load,
  output logic [31:0] o_fetch_vector,
  output logic [1:0] o_prescaler_sel,
  output logic [1:0] o_mode
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [1:0] strap_s_q, wake_s_q;
  logic [2:0] ls_s_q;
  always_ff @(posedge i_clock) begin
    strap_s_q <= {strap_s_q[0], i_pll_bypass_strap};
    wake_s_q <= {wake_s_q[0], i_wake};
    ls_s_q <= {ls_s_q[1:0], i_low_speed_clock};
  end

  rcsc_ctrl0_t ctrl0_q;
  rcsc_ctrl1_t ctrl1_q;
  rcsc_state_t state_q;
  logic bypass_q, boot_q, slow_before_q;
  logic [1:0] fosc_cnt_q;
  logic fc_tick, fs_tick, gear_tick, sys_tick;
  logic [2:0] gear_cnt_q;
  logic [3:0] gear_mask;
  logic [$clog2(LS_STABLE_EDGES+1)-1:0] ls_cnt_q;
  logic ls_stable_q;
  logic [$clog2(WARMUP_CYCLES+1)-1:0] wup_cnt_q;
  logic src_q, gap_q;
  logic wr, rd_hit;
  logic [3:0] idx;

  // ****************************************************************
  // Reset sequencing and strap capture
  // ****************************************************************
  // RAM has no clear path here; its contents survive reset RL7
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      boot_q <= 1'b1;
      o_periph_rst <= 1'b1; // RL5
      o_port_gpio_init <= 1'b1; // RL6
      o_vector_load <= 1'b0;
      o_fetch_vector <= RESET_VECTOR; // RL4
    end else begin
      boot_q <= 1'b0;
      o_periph_rst <= 1'b0;
      o_port_gpio_init <= 1'b0;
      o_vector_load <= boot_q; // RL4
      o_fetch_vector <= RESET_VECTOR;
    end
  end

  // Strap level is caught at the first edge after release, never under reset
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) bypass_q <= 1'b0;
    else if (boot_q) bypass_q <= ~strap_s_q[1]; // RL2
  end

  // ****************************************************************
  // High-speed clock: PLL x4 or bypass, optional divide-by-2, gear
  // ****************************************************************
  // i_clock stands for the PLL output; bypass yields one tick in PLL_MULT with osc_divide_factor_bit set, one in twice that while it is clear
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) fosc_cnt_q <= 2'h0;
    else fosc_cnt_q <= fosc_cnt_q + 2'h1;
  end

  // Bypassed input divided by 2: one tick in every second round of fosc_cnt_q
  logic half_q;
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) half_q <= 1'b0;
    else if (fosc_cnt_q == 2'h3) half_q <= ~half_q;
  end

  always_comb begin
    if (!bypass_q) fc_tick = 1'b1; // RL12
    else if (ctrl1_q.osc_divide_factor_bit) fc_tick = (fosc_cnt_q == 2'h0); // RL14
    else fc_tick = (fosc_cnt_q == 2'h0) && half_q;
  end
  logic fc_eff;
  assign fc_eff = fc_tick;

  assign gear_mask = 4'((1 << ctrl1_q.gear) - 1);
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) gear_cnt_q <= 3'h0;
    else if (fc_eff) gear_cnt_q <= gear_cnt_q + 3'h1;
  end
  assign gear_tick = fc_eff && ((gear_cnt_q & gear_mask[2:0]) == 3'(gear_mask)); // RL3 RL13

  // ****************************************************************
  // Low-speed clock: edge ticks and stability
  // ****************************************************************
  assign fs_tick = ctrl0_q.xten && ls_s_q[1] && !ls_s_q[2]; // RL8
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || !ctrl0_q.xten) begin
      ls_cnt_q <= '0;
      ls_stable_q <= 1'b0;
    end else if (fs_tick && !ls_stable_q) begin
      ls_cnt_q <= ls_cnt_q + 1'b1;
      ls_stable_q <= (32'(ls_cnt_q) == LS_STABLE_EDGES - 1);
    end
  end

  // ****************************************************************
  // Glitch-free source switch
  // ****************************************************************
  // Old source is dropped only at its own tick, new one starts at its own tick
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      src_q <= 1'b0;
      gap_q <= 1'b0;
    end else if (gap_q) begin
      if (ctrl1_q.system_clock_source_select ? fs_tick : gear_tick) begin
        src_q <= ctrl1_q.system_clock_source_select; // RL20
        gap_q <= 1'b0;
      end
    end else if (src_q != ctrl1_q.system_clock_source_select &&
                 (src_q ? fs_tick : gear_tick)) begin
      gap_q <= 1'b1; // RL20
    end
  end
  assign sys_tick = !gap_q && (src_q ? fs_tick : gear_tick);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_sys_clk_en <= 1'b0;
      o_cpu_clk_en <= 1'b0;
      o_periph_clk_en <= 1'b0;
      o_rtc_clk_en <= 1'b0;
      o_prescaler_sel <= 2'h0;
      o_mode <= 2'h0;
    end else begin
      o_sys_clk_en <= sys_tick && state_q == ST_RUN;
      o_cpu_clk_en <= sys_tick && state_q == ST_RUN; // RL15 RL16
      o_periph_clk_en <= sys_tick && state_q == ST_RUN && !src_q;
      o_rtc_clk_en <= fs_tick && state_q != ST_STOP; // RL16
      o_prescaler_sel <= ctrl0_q.prck;
      o_mode <= state_q;
    end
  end

  // ****************************************************************
  // Standby state machine and registers
  // ****************************************************************
  assign idx = i_wb_adr[ADDR_W-1:ADDR_LSB];
  assign wr = i_wb_cyc && i_wb_stb && i_wb_we && !o_wb_ack && i_wb_sel[0];

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      state_q <= ST_RUN;
      ctrl0_q <= CTRL0_RST;
      ctrl1_q <= CTRL1_RST; // RL3 RL14
      slow_before_q <= 1'b0;
      wup_cnt_q <= '0;
    end else begin
      if (wup_cnt_q != '0) wup_cnt_q <= wup_cnt_q - 1'b1;
      unique case (state_q)
        ST_RUN: begin
          if (wr && idx == IDX_CTRL0) begin
            ctrl0_q <= rcsc_ctrl0_t'({i_wb_dat[7:3], 1'b0, i_wb_dat[1:0]});
            if (i_wb_dat[2]) wup_cnt_q <= ($bits(wup_cnt_q))'(WARMUP_CYCLES);
          end
          if (wr && idx == IDX_CTRL1) begin
            ctrl1_q <= rcsc_ctrl1_t'({3'h0, i_wb_dat[4:3], 1'b0, i_wb_dat[1:0]});
            // Low-speed select kept only once that clock is stable
            ctrl1_q.system_clock_source_select <= i_wb_dat[5] && ls_stable_q; // RL9
          end
          if (wr && idx == IDX_STBY) begin
            if (i_wb_dat[STBY_STOP_BIT]) state_q <= ST_STOP;
            else if (i_wb_dat[STBY_SLEEP_BIT] && ls_stable_q) begin
              slow_before_q <= ctrl1_q.system_clock_source_select; // RL9
              state_q <= ST_SLEEP;
            end
          end
        end
        ST_SLEEP: if (wake_s_q[1]) begin
          ctrl1_q.system_clock_source_select <= slow_before_q; // RL10
          state_q <= ST_RUN;
        end
        ST_STOP: if (wake_s_q[1]) begin
          wup_cnt_q <= ($bits(wup_cnt_q))'(WARMUP_CYCLES);
          ctrl0_q.xen <= ctrl0_q.rxen;
          ctrl0_q.xten <= ctrl0_q.rxten;
          state_q <= ST_WARM;
        end
        ST_WARM: if (wup_cnt_q == '0) begin
          ctrl1_q.system_clock_source_select <= ctrl0_q.rsysck; // RL11
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // Read data; unmapped indices read zero and still acknowledge
  logic [31:0] rd_d;
  always_comb begin
    rd_hit = 1'b1;
    unique case (idx)
      IDX_CTRL0: rd_d = {24'h0, ctrl0_q.xen, ctrl0_q.xten, ctrl0_q.rxen, ctrl0_q.rxten,
                         ctrl0_q.rsysck, wup_cnt_q != '0, ctrl0_q.prck};
      IDX_CTRL1: rd_d = {24'h0, ctrl1_q};
      IDX_STBY: rd_d = {27'h0, bypass_q, ls_stable_q, 1'b0, state_q};
      default: begin
        rd_d = 32'h0;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
    end else begin
      o_wb_ack <= i_wb_cyc && i_wb_stb && !o_wb_ack;
      o_wb_dat <= rd_hit ? rd_d : 32'h0;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  sequence s_sleep_cmd;
    wr && idx == IDX_STBY && i_wb_dat[STBY_SLEEP_BIT] && !i_wb_dat[STBY_STOP_BIT] &&
      state_q == ST_RUN;
  endsequence

  a_sleep_needs_stable: assert property ( // RL9
    s_sleep_cmd |=> (state_q == ST_SLEEP) == $past(ls_stable_q))
    else $error("sleep entry not tied to low-speed stability");
  a_slow_needs_stable: assert property ( // RL9
    $rose(ctrl1_q.system_clock_source_select) && state_q == ST_RUN |-> $past(ls_stable_q))
    else $error("slow select without stable low-speed clock");
  a_sleep_resume: assert property ( // RL10
    state_q == ST_SLEEP && wake_s_q[1] |=>
    state_q == ST_RUN && ctrl1_q.system_clock_source_select == $past(slow_before_q))
    else $error("sleep exit did not restore mode");
  a_stop_exit_mode: assert property ( // RL11
    state_q == ST_WARM && wup_cnt_q == '0 |=>
    ctrl1_q.system_clock_source_select == $past(ctrl0_q.rsysck))
    else $error("stop exit mode differs from programmed");
  a_sleep_cpu_off: assert property (state_q != ST_RUN |=> !o_cpu_clk_en) // RL16
    else $error("cpu clock running in standby");
  a_gap_no_tick: assert property (gap_q |=> !o_sys_clk_en) // RL20
    else $error("system clock pulse during source switch");
  a_pll_full_rate: assert property ( // RL12 RL13
    !bypass_q && ctrl1_q.gear == 2'h0 && !src_q && !gap_q &&
    state_q == ST_RUN |=> o_sys_clk_en)
    else $error("undivided PLL clock missing");
  // Release edge still runs the reset branch, so the pulse follows a boot cycle out of reset
  a_vector_pulse: assert property ( // RL4
    boot_q && i_rst_n |=> o_vector_load && o_fetch_vector == RESET_VECTOR)
    else $error("reset vector not issued");
  a_ack_one_cycle: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held beyond one cycle");
  // A gear write may legally cut the spacing short; only ticks still at divide-by-eight count
  a_gear_eight: assert property ( // RL3
    ctrl1_q.gear == 2'h3 && gear_tick |=> (!gear_tick || ctrl1_q.gear != 2'h3) [*7])
    else $error("gear divide-by-eight spacing wrong");
endmodule // rcsc_top
`default_nettype wire

// ==== rcsc_pkg.sv ====
// Package: register map, field layouts, reset values and modes of the clock/standby block
package rcsc_pkg;
  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [3:0] IDX_CTRL0 = 4'h0;
  localparam logic [3:0] IDX_CTRL1 = 4'h1;
  localparam logic [3:0] IDX_STBY = 4'h2;
  localparam int ADDR_W = 6;
  localparam int ADDR_LSB = 2;

  // ****************************************************************
  // Field layouts
  // ****************************************************************
  typedef struct packed {
    logic xen;
    logic xten;
    logic rxen;
    logic rxten;
    logic rsysck;
    logic wuef;
    logic [1:0] prck;
  } rcsc_ctrl0_t;

  typedef struct packed {
    logic [1:0] rsvd;
    logic system_clock_source_select;
    logic fpsel;
    logic osc_divide_factor_bit;
    logic rsvd2;
    logic [1:0] gear;
  } rcsc_ctrl1_t;

  localparam rcsc_ctrl0_t CTRL0_RST = '{xen: 1'b1, xten: 1'b0, rxen: 1'b1, rxten: 1'b0,
    rsysck: 1'b0, wuef: 1'b0, prck: 2'h0};
  localparam rcsc_ctrl1_t CTRL1_RST = '{rsvd: 2'h0, system_clock_source_select: 1'b0,
    fpsel: 1'b0, osc_divide_factor_bit: 1'b0, rsvd2: 1'b0, gear: 2'h3};

  localparam int STBY_SLEEP_BIT = 0;
  localparam int STBY_STOP_BIT = 1;
  localparam int STBY_STABLE_BIT = 3;
  localparam int STBY_STRAP_BIT = 4;

  // ****************************************************************
  // Modes, constants
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_SLEEP = 2'b01,
    ST_STOP = 2'b10,
    ST_WARM = 2'b11
  } rcsc_state_t;

  localparam logic [31:0] RESET_VECTOR = 32'hBFC0_0000;
  localparam int PLL_MULT = 4;
  localparam int RST_MIN_CYCLES = 12;
endpackage

// ==== rcsc_ext_osc.sv ====
// Behavioural model of the board: low-speed crystal and PLL strap pin
`timescale 1ns/1ns
`default_nettype none
module rcsc_ext_osc #(
  parameter int HALF_CYCLES = 5,
  parameter logic STRAP = 1'b1
) (
  // Board side
  input wire logic i_clock,
  input wire logic i_osc_on,
  output logic o_low_speed_clock,
  output logic o_pll_bypass_strap
);
  int cnt = 0;
  assign o_pll_bypass_strap = STRAP;
  // An unfitted crystal is a flat line, never a slow clock
  always @(posedge i_clock) begin
    if (!i_osc_on) begin
      cnt <= 0;
      o_low_speed_clock <= 1'b0;
    end else if (cnt == HALF_CYCLES - 1) begin
      cnt <= 0;
      o_low_speed_clock <= ~o_low_speed_clock;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // rcsc_ext_osc
`default_nettype wire

// ==== rcsc_top_tb_top.sv ====
// Self-checking bench for the clock, reset and standby control block
`timescale 1ns/1ns
`default_nettype none
module rcsc_top_tb_top;
  import rcsc_pkg::*;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_wake = 1'b0;
  logic osc_on = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [31:0] wdat = 32'h0;
  logic [7:0] rd;
  logic ack, sys_en, cpu_en, per_en, rtc_en, per_rst, gpio_init, vec_ld, ls_clk, strap;
  logic [31:0] rdat, fvec;
  logic [1:0] psel, mode;
  int bad_count = 0;
  int num_checks = 0;
  int n_sys = 0, n_cpu = 0, n_per = 0, n_rtc = 0, n_vec = 0;

  always #20 i_clock = ~i_clock;

  rcsc_ext_osc i_rcsc_ext_osc (.i_clock(i_clock), .i_osc_on(osc_on),
    .o_low_speed_clock(ls_clk), .o_pll_bypass_strap(strap));
  // Short warm-up and stability counts keep the run brief
  rcsc_top #(.WARMUP_CYCLES(16), .LS_STABLE_EDGES(2)) i_rcsc_top (.i_clock(i_clock),
    .i_rst_n(i_rst_n), .i_pll_bypass_strap(strap), .i_low_speed_clock(ls_clk),
    .i_wake(i_wake), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_ack(ack), .o_wb_dat(rdat),
    .o_sys_clk_en(sys_en), .o_cpu_clk_en(cpu_en), .o_periph_clk_en(per_en),
    .o_rtc_clk_en(rtc_en), .o_periph_rst(per_rst), .o_port_gpio_init(gpio_init),
    .o_vector_load(vec_ld), .o_fetch_vector(fvec), .o_prescaler_sel(psel), .o_mode(mode));

  always @(posedge i_clock) begin
    n_sys += (sys_en === 1'b1);
    n_cpu += (cpu_en === 1'b1);
    n_per += (per_en === 1'b1);
    n_rtc += (rtc_en === 1'b1);
    n_vec += (vec_ld === 1'b1);
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    do begin
      @(posedge i_clock);
      n++;
    end while (ack !== 1'b1 && n < 20);
    rd = rdat[7:0];
    if (n >= 20) check(32'h0, 32'h1, "no ack");
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rchk(input logic [3:0] idx, input logic [7:0] exp, input string what);
    wb(1'b0, idx, 8'h00);
    check({24'h0, rd}, {24'h0, exp}, what);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  // Counted on falling edges so the clear never races the counting edge
  task automatic window(input int n);
    @(negedge i_clock);
    n_sys = 0;
    n_cpu = 0;
    n_per = 0;
    n_rtc = 0;
    repeat (n) @(negedge i_clock);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (12) @(posedge i_clock);
    check({31'h0, per_rst}, 32'h1, "periph reset held");
    check({31'h0, gpio_init}, 32'h1, "gpio init held");
    i_rst_n <= 1'b1;
    wait_cyc(4);
    check({31'h0, per_rst}, 32'h0, "periph reset off");
    check({31'h0, gpio_init}, 32'h0, "gpio init off");
    check(n_vec, 32'h1, "vector load");
    check(fvec, 32'hBFC0_0000, "vector");
    rchk(IDX_CTRL0, 8'hA0, "ctrl0 reset");
    rchk(IDX_CTRL1, 8'h03, "ctrl1 reset");
    rchk(IDX_STBY, 8'h00, "strap seen");
    rchk(4'h5, 8'h00, "unmapped");
    $display("test reset done");
    for (int g = 0; g < 4; g++) begin
      wb(1'b1, IDX_CTRL1, 8'(g));
      wait_cyc(16);
      window(64);
      check(n_sys, 32'(64 >> g), "gear rate");
      check(n_per, 32'(64 >> g), "periph gear rate");
    end
    $display("test gear done");
    wb(1'b1, IDX_CTRL1, 8'h20);
    rchk(IDX_CTRL1, 8'h00, "slow refused");
    wb(1'b1, IDX_STBY, 8'h01);
    wait_cyc(4);
    check(mode, ST_RUN, "sleep refused");
    osc_on <= 1'b1;
    wb(1'b1, IDX_CTRL0, 8'hE2);
    wait_cyc(80);
    rchk(IDX_STBY, 8'h08, "low-speed stable");
    check(psel, 2'h2, "prescaler select");
    wb(1'b1, IDX_CTRL1, 8'h20);
    // Let the switch finish: old tick, gap, then the first low-speed tick
    wait_cyc(16);
    window(40);
    check(n_per, 0, "periph in slow");
    check(n_sys, 32'd4, "slow rate");
    check(n_cpu, 32'd4, "cpu on low-speed");
    wb(1'b1, IDX_STBY, 8'h01);
    wait_cyc(4);
    check(mode, ST_SLEEP, "sleep");
    window(60);
    check(n_cpu, 0, "cpu halted");
    check(n_rtc, 32'd6, "rtc runs");
    wait_cyc(1);
    i_wake <= 1'b1;
    wait_cyc(8);
    check(mode, ST_RUN, "woke");
    i_wake <= 1'b0;
    wait_cyc(6);
    rchk(IDX_CTRL1, 8'h20, "slow resumed");
    $display("test sleep done");
    wb(1'b1, IDX_CTRL1, 8'h03);
    wb(1'b1, IDX_CTRL0, 8'hF8);
    wb(1'b1, IDX_STBY, 8'h02);
    wait_cyc(4);
    check(mode, ST_STOP, "stop");
    window(40);
    check(n_rtc + n_sys, 0, "stop halts");
    wait_cyc(1);
    i_wake <= 1'b1;
    wait_cyc(6);
    check(mode, ST_WARM, "warm-up");
    i_wake <= 1'b0;
    wait_cyc(40);
    check(mode, ST_RUN, "stop exit");
    rchk(IDX_CTRL1, 8'h23, "source after stop");
    rchk(IDX_CTRL0, 8'hF8, "ctrl0 after stop");
    $display("test stop done");
    end_of_test();
  end

  initial begin
    #800000;
    bad_count++;
    end_of_test();
  end
endmodule // rcsc_top_tb_top
`default_nettype wire
